//--- rtl/timer_consts.svh
// Register indices, field positions, reset values and counts of the timer.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define ADDR_W          10
`define IDX_W           8
`define DATA_W          32
`define BYTE_W          8

`define IDX_CTL_A       8'hB0
`define IDX_CTL_B       8'hB1
`define IDX_COUNTER     8'hB2
`define IDX_CMP_A       8'hB3
`define IDX_CMP_B       8'hB4
`define IDX_ASYNC       8'hB6
`define IDX_MASK        8'h70
`define IDX_FLAGS       8'h38
`define IDX_GTC         8'h43

`define RESET_BYTE      8'h00
`define CTL_B_WMASK     8'h0F
`define MASK_WMASK      8'h07
`define MAX_VALUE       8'hFF
`define BOTTOM_VALUE    8'h00
`define ONE_BYTE        8'h01

`define GTC_TSM         7
`define GTC_PSR         1
`define ASY_EXTERNAL_CLOCK_ENABLE       6
`define ASY_AS2         5
`define FLAG_OVF        0
`define FLAG_CMPA       1
`define FLAG_CMPB       2
`define NUM_FLAGS       3
`define WGM_HI_BIT      3
`define CS_MSB          2

`define SLOT_CTL_B      3'h0
`define SLOT_CTL_A      3'h1
`define SLOT_CMP_B      3'h2
`define SLOT_CMP_A      3'h3
`define SLOT_COUNTER    3'h4
`define SLOT_NONE       3'h5
`define NUM_SLOTS       5

`define PRE_W           10
`define PRE_DIV8_MSB    2
`define PRE_DIV32_MSB   4
`define PRE_DIV64_MSB   5
`define PRE_DIV128_MSB  6
`define PRE_DIV256_MSB  7
`define PRE_DIV1024_MSB 9

`endif

//--- rtl/timer_pkg.sv
// Types shared by the timer design files.
package timer_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h0
  } bus_state_type;

  typedef enum logic [2:0] {
    WGM_NORMAL    = 3'h0,
    WGM_PC_MAX    = 3'h1,
    WGM_CTC       = 3'h2,
    WGM_FAST_MAX  = 3'h3,
    WGM_RSVD_A    = 3'h4,
    WGM_PC_CMPA   = 3'h5,
    WGM_RSVD_B    = 3'h6,
    WGM_FAST_CMPA = 3'h7
  } wave_mode_type;

endpackage

//--- rtl/slow_tick_sync.sv
// Synchroniser that turns rising edges of the slow oscillator pin into ticks.
`timescale 1ns/1ps
module slow_tick_sync (
  // Clock, reset and enable.
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic ce,
  // Slow oscillator pin and tick out.
  input  wire logic slow_osc_input_pin,
  output logic      slow_tick
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic sync1_next;
  logic sync2_next;
  logic prev_next;

  always_comb begin
    sync1_next = sync1_reg;
    sync2_next = sync2_reg;
    prev_next  = prev_reg;
    if (ce) begin
      sync1_next = slow_osc_input_pin;
      sync2_next = sync1_reg;
      prev_next  = sync2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  // Only the second stage and its delayed copy feed the edge detector.
  assign slow_tick = ce & sync2_reg & ~prev_reg;

endmodule

//--- rtl/async_timer_flags_sync.sv
// Timer flags, asynchronous status and update logic behind an Avalon slave.
// Behaviour
// - Compare B flag sets on match with compare B; clears by vector or one.
// - Compare A flag sets on match with compare A; clears by vector or one.
// - Compare interrupt only with global enable, channel enable and flag set.
// - Overflow flag sets on overflow; clears by vector or written one.
// - Phase correct modes set overflow flag on turning at bottom.
// - Overflow interrupt only with global enable, its enable and flag set.
// - Top bit of the asynchronous status register always reads zero.
// - External clock bit with async selects pin clock; crystal runs when clear.
// - Async select low clocks from system clock, high from slow pin.
// - Async counter write sets busy; cleared once counter is loaded.
// - Async compare write sets its busy; cleared once register is loaded.
// - Async control write sets its busy; cleared once register is loaded.
// - Counter reads live value; compare and control read holding registers.
// - Writing one to prescaler reset resets prescaler; bit normally self-clears.
// - In async mode the reset bit stays until slow-domain reset happens.
// - With synchronization mode set, hardware never clears prescaler reset.
// - Mask bits 0, 1, 2 enable overflow, compare A, compare B.
`timescale 1ns/1ps
`include "timer_consts.svh"
module async_timer_flags_sync (
  // Clock, reset and enable.
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  // Avalon-MM slave.
  input  wire logic [`ADDR_W-1:0]   address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [`DATA_W-1:0]   writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [`DATA_W-1:0]   readdata,
  output logic                      waitrequest,
  // Processor side.
  input  wire logic                 global_int_enable,
  input  wire logic                 overflow_vector_ack,
  input  wire logic                 compare_a_vector_ack,
  input  wire logic                 compare_b_vector_ack,
  output logic                      overflow_irq,
  output logic                      compare_a_irq,
  output logic                      compare_b_irq,
  // Slow oscillator.
  input  wire logic                 slow_osc_input_pin,
  output logic                      crystal_osc_enable,
  output logic                      ext_clock_buffer_enable
);

  timer_pkg::bus_state_type bus_state_reg;
  timer_pkg::bus_state_type bus_state_next;
  logic [`DATA_W-1:0]   readdata_reg;
  logic [`DATA_W-1:0]   readdata_next;
  logic [`BYTE_W-1:0]   hold_reg [`NUM_SLOTS];
  logic [`BYTE_W-1:0]   hold_next [`NUM_SLOTS];
  logic [`BYTE_W-1:0]   act_reg [`NUM_SLOTS];
  logic [`BYTE_W-1:0]   act_next [`NUM_SLOTS];
  logic [`NUM_SLOTS-1:0] busy_reg;
  logic [`NUM_SLOTS-1:0] busy_next;
  logic                 external_clock_enable_reg;
  logic                 external_clock_enable_next;
  logic                 as2_reg;
  logic                 as2_next;
  logic                 tsm_reg;
  logic                 tsm_next;
  logic                 psr_reg;
  logic                 psr_next;
  logic [`PRE_W-1:0]    pre_reg;
  logic [`PRE_W-1:0]    pre_next;
  logic                 down_reg;
  logic                 down_next;
  logic                 block_reg;
  logic                 block_next;
  logic [`NUM_FLAGS-1:0] flag_reg;
  logic [`NUM_FLAGS-1:0] flag_next;
  logic [`NUM_FLAGS-1:0] mask_reg;
  logic [`NUM_FLAGS-1:0] mask_next;
  logic [`NUM_FLAGS-1:0] irq_reg;
  logic [`NUM_FLAGS-1:0] irq_next;
  logic                 xtal_reg;
  logic                 xtal_next;
  logic                 extbuf_reg;
  logic                 extbuf_next;
  logic                 slow_tick;

  slow_tick_sync u_slow_tick_sync (
    .mclk               (mclk),
    .reset_n            (reset_n),
    .ce                 (ce),
    .slow_osc_input_pin (slow_osc_input_pin),
    .slow_tick          (slow_tick)
  );

  // Maps a register index to its holding slot.
  function automatic logic [2:0] slot_of(input logic [`IDX_W-1:0] idx);
    case (idx)
      `IDX_CTL_B:   slot_of = `SLOT_CTL_B;
      `IDX_CTL_A:   slot_of = `SLOT_CTL_A;
      `IDX_CMP_B:   slot_of = `SLOT_CMP_B;
      `IDX_CMP_A:   slot_of = `SLOT_CMP_A;
      `IDX_COUNTER: slot_of = `SLOT_COUNTER;
      default:      slot_of = `SLOT_NONE;
    endcase
  endfunction

  // True when the prescaler has reached the tap the clock select asks for.
  function automatic logic pre_hit(input logic [`CS_MSB:0] cs,
                                   input logic [`PRE_W-1:0] pre);
    case (cs)
      3'h1:    pre_hit = 1'b1;
      3'h2:    pre_hit = &pre[`PRE_DIV8_MSB:0];
      3'h3:    pre_hit = &pre[`PRE_DIV32_MSB:0];
      3'h4:    pre_hit = &pre[`PRE_DIV64_MSB:0];
      3'h5:    pre_hit = &pre[`PRE_DIV128_MSB:0];
      3'h6:    pre_hit = &pre[`PRE_DIV256_MSB:0];
      3'h7:    pre_hit = &pre[`PRE_DIV1024_MSB:0];
      default: pre_hit = 1'b0;
    endcase
  endfunction

  logic [`IDX_W-1:0]     idx;
  logic [2:0]            slot;
  logic                  wr_fire;
  logic                  base_tick;
  logic                  timer_tick;
  timer_pkg::wave_mode_type wgm;
  logic [`BYTE_W-1:0]    top;
  logic [`BYTE_W-1:0]    cnt;
  logic                  phase_correct;
  logic [`NUM_FLAGS-1:0] flag_set;
  logic [`NUM_FLAGS-1:0] flag_clr;
  logic [`BYTE_W-1:0]    wbyte;
  logic [`BYTE_W-1:0]    rbyte;

  assign idx   = address[`ADDR_W-1:2];
  assign slot  = slot_of(idx);
  assign wbyte = writedata[`BYTE_W-1:0];
  // A write takes effect at the edge where waitrequest is seen low.
  assign wr_fire = write & byteenable[0] & (bus_state_reg == timer_pkg::BUS_ACK);
  assign base_tick  = as2_reg ? slow_tick : 1'b1;
  assign timer_tick = base_tick & ~psr_reg &
                      pre_hit(act_reg[`SLOT_CTL_B][`CS_MSB:0], pre_reg);
  assign wgm = timer_pkg::wave_mode_type'({act_reg[`SLOT_CTL_B][`WGM_HI_BIT],
                                          act_reg[`SLOT_CTL_A][1:0]});
  assign cnt = act_reg[`SLOT_COUNTER];
  assign phase_correct = (wgm == timer_pkg::WGM_PC_MAX) ||
                         (wgm == timer_pkg::WGM_PC_CMPA);
  assign top = ((wgm == timer_pkg::WGM_CTC) || (wgm == timer_pkg::WGM_PC_CMPA) ||
                (wgm == timer_pkg::WGM_FAST_CMPA)) ?
               act_reg[`SLOT_CMP_A] : `MAX_VALUE;

  // Read mux, also the source of the registered read data.
  always_comb begin
    rbyte = `RESET_BYTE;
    case (idx)
      `IDX_COUNTER: rbyte = cnt;
      `IDX_CTL_A, `IDX_CTL_B, `IDX_CMP_A, `IDX_CMP_B:
        rbyte = hold_reg[slot];
      `IDX_ASYNC: begin
        rbyte = `RESET_BYTE;
        rbyte[`ASY_EXTERNAL_CLOCK_ENABLE] = external_clock_enable_reg;
        rbyte[`ASY_AS2]   = as2_reg;
        rbyte[`NUM_SLOTS-1:0] = busy_reg;
      end
      `IDX_MASK:  rbyte[`NUM_FLAGS-1:0] = mask_reg;
      `IDX_FLAGS: rbyte[`NUM_FLAGS-1:0] = flag_reg;
      `IDX_GTC: begin
        rbyte[`GTC_TSM] = tsm_reg;
        rbyte[`GTC_PSR] = psr_reg;
      end
      default: rbyte = `RESET_BYTE;
    endcase
  end

  // Bus handshake: one wait cycle, then the answer.
  always_comb begin
    bus_state_next = bus_state_reg;
    readdata_next  = readdata_reg;
    case (bus_state_reg)
      timer_pkg::BUS_IDLE: begin
        if (read || write) begin
          bus_state_next = timer_pkg::BUS_ACK;
          readdata_next  = {{(`DATA_W-`BYTE_W){1'b0}}, rbyte};
        end
      end
      timer_pkg::BUS_ACK: bus_state_next = timer_pkg::BUS_IDLE;
      default: bus_state_next = timer_pkg::BUS_IDLE;
    endcase
  end

  // Holding registers, active registers, busy bits and the counter.
  always_comb begin
    logic [`BYTE_W-1:0] c;
    c = cnt;
    hold_next  = hold_reg;
    act_next   = act_reg;
    busy_next  = busy_reg;
    down_next  = down_reg;
    block_next = block_reg;
    flag_set   = '0;
    if (timer_tick) begin
      block_next = 1'b0;
      if (!block_reg) begin
        flag_set[`FLAG_CMPA] = (c == act_reg[`SLOT_CMP_A]);
        flag_set[`FLAG_CMPB] = (c == act_reg[`SLOT_CMP_B]);
      end
      if (phase_correct) begin
        if (!down_reg) begin
          if (c == top) begin
            down_next = 1'b1;
            c = c - `ONE_BYTE;
          end else begin
            c = c + `ONE_BYTE;
          end
        end else if (c == `BOTTOM_VALUE) begin
          down_next = 1'b0;
          flag_set[`FLAG_OVF] = 1'b1;
          c = c + `ONE_BYTE;
        end else begin
          c = c - `ONE_BYTE;
        end
      end else begin
        down_next = 1'b0;
        flag_set[`FLAG_OVF] = (wgm == timer_pkg::WGM_FAST_CMPA) ?
                              (c == top) : (c == `MAX_VALUE);
        c = (c == top) ? `BOTTOM_VALUE : c + `ONE_BYTE;
      end
    end
    act_next[`SLOT_COUNTER] = c;
    // Transfers wait for a synchronised slow tick before busy clears.
    for (int i = 0; i < `NUM_SLOTS; i++) begin
      if (busy_reg[i] && slow_tick) begin
        act_next[i]  = hold_reg[i];
        busy_next[i] = 1'b0;
        if (i == `SLOT_COUNTER) begin
          block_next = 1'b1;
        end
      end
    end
    if (wr_fire && (slot != `SLOT_NONE)) begin
      hold_next[slot] = (slot == `SLOT_CTL_B) ? (wbyte & `CTL_B_WMASK) : wbyte;
      if (as2_reg) begin
        busy_next[slot] = 1'b1;
      end else begin
        act_next[slot] = hold_next[slot];
        if (slot == `SLOT_COUNTER) begin
          block_next = 1'b1;
        end
      end
    end
  end

  // Status, prescaler, flags, masks and interrupt outputs.
  always_comb begin
    external_clock_enable_next = external_clock_enable_reg;
    as2_next   = as2_reg;
    tsm_next   = tsm_reg;
    psr_next   = psr_reg;
    mask_next  = mask_reg;
    pre_next   = pre_reg;
    if (base_tick) begin
      if (psr_reg) begin
        pre_next = '0;
        if (!tsm_reg) begin
          psr_next = 1'b0;
        end
      end else begin
        pre_next = pre_reg + 1'b1;
      end
    end
    flag_clr = '0;
    flag_clr[`FLAG_OVF]  = overflow_vector_ack;
    flag_clr[`FLAG_CMPA] = compare_a_vector_ack;
    flag_clr[`FLAG_CMPB] = compare_b_vector_ack;
    if (wr_fire) begin
      case (idx)
        `IDX_ASYNC: begin
          external_clock_enable_next = wbyte[`ASY_EXTERNAL_CLOCK_ENABLE];
          as2_next   = wbyte[`ASY_AS2];
        end
        `IDX_MASK:  mask_next = wbyte[`NUM_FLAGS-1:0];
        `IDX_FLAGS: flag_clr = flag_clr | wbyte[`NUM_FLAGS-1:0];
        `IDX_GTC: begin
          tsm_next = wbyte[`GTC_TSM];
          if (wbyte[`GTC_PSR]) begin
            psr_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // A set in the same cycle as a clear keeps the flag.
    flag_next = (flag_reg & ~flag_clr) | flag_set;
    irq_next  = {`NUM_FLAGS{global_int_enable}} & mask_reg & flag_next;
    xtal_next   = as2_reg & ~external_clock_enable_reg;
    extbuf_next = as2_reg & external_clock_enable_reg;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_state_reg <= timer_pkg::BUS_IDLE;
      readdata_reg  <= '0;
      for (int i = 0; i < `NUM_SLOTS; i++) begin
        hold_reg[i] <= `RESET_BYTE;
        act_reg[i]  <= `RESET_BYTE;
      end
      busy_reg   <= '0;
      external_clock_enable_reg  <= 1'b0;
      as2_reg    <= 1'b0;
      tsm_reg    <= 1'b0;
      psr_reg    <= 1'b0;
      pre_reg    <= '0;
      down_reg   <= 1'b0;
      block_reg  <= 1'b0;
      flag_reg   <= '0;
      mask_reg   <= '0;
      irq_reg    <= '0;
      xtal_reg   <= 1'b0;
      extbuf_reg <= 1'b0;
    end else if (ce) begin
      bus_state_reg <= bus_state_next;
      readdata_reg  <= readdata_next;
      hold_reg   <= hold_next;
      act_reg    <= act_next;
      busy_reg   <= busy_next;
      external_clock_enable_reg  <= external_clock_enable_next;
      as2_reg    <= as2_next;
      tsm_reg    <= tsm_next;
      psr_reg    <= psr_next;
      pre_reg    <= pre_next;
      down_reg   <= down_next;
      block_reg  <= block_next;
      flag_reg   <= flag_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      xtal_reg   <= xtal_next;
      extbuf_reg <= extbuf_next;
    end
  end

  assign readdata    = readdata_reg;
  // The idle state carries a one in bit 0, so waitrequest is a flop bit.
  assign waitrequest = bus_state_reg[0];
  assign overflow_irq  = irq_reg[`FLAG_OVF];
  assign compare_a_irq = irq_reg[`FLAG_CMPA];
  assign compare_b_irq = irq_reg[`FLAG_CMPB];
  assign crystal_osc_enable      = xtal_reg;
  assign ext_clock_buffer_enable = extbuf_reg;

endmodule

//--- testbench/timer_sva.sv
// Checker for the register slave and the status outputs of the timer.
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_sva (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Processor side and oscillator.
  input wire logic        global_int_enable,
  input wire logic        compare_a_vector_ack,
  input wire logic        overflow_irq,
  input wire logic        compare_a_irq,
  input wire logic        compare_b_irq,
  input wire logic        crystal_osc_enable,
  input wire logic        ext_clock_buffer_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  wire wr_async = !waitrequest && write && byteenable[0]
                  && address[9:2] == `IDX_ASYNC;

  AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("answer cycle lasted longer than one cycle");
  AST_WAIT_IDLE: assert property (!read && !write && waitrequest |=> waitrequest)
    else $error("answer without a request");
  AST_TAKE: assert property ($rose(read) |=> !waitrequest)
    else $error("read not answered after one wait cycle");
  AST_TOP_BIT: assert property (!waitrequest && read &&
    address[9:2] == `IDX_ASYNC |-> readdata[31:7] == 25'h0)
    else $error("status top bit read as one");
  AST_OVF_GIE: assert property (overflow_irq |-> $past(global_int_enable))
    else $error("overflow request without global enable");
  AST_CMP_GIE: assert property (!global_int_enable |=>
    !compare_a_irq && !compare_b_irq)
    else $error("compare request without global enable");
  AST_VEC_A: assert property (compare_a_vector_ack |=> !compare_a_irq)
    else $error("compare A request survived its vector");
  AST_XTAL_EXCL: assert property (crystal_osc_enable |->
    !ext_clock_buffer_enable)
    else $error("crystal and external buffer both enabled");
  AST_XTAL_ON: assert property (wr_async && writedata[6:5] == 2'h1
    |-> ##[1:2] crystal_osc_enable)
    else $error("crystal not started in async crystal mode");
  AST_EXT_ON: assert property (wr_async && writedata[6:5] == 2'h3
    |-> ##[1:2] ext_clock_buffer_enable)
    else $error("external clock buffer not enabled");

  cover property (compare_a_irq && compare_b_irq);
  cover property (overflow_irq);
  cover property (ext_clock_buffer_enable);
endmodule

bind async_timer_flags_sync timer_sva chk_u (
  .mclk, .reset_n, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .global_int_enable, .compare_a_vector_ack,
  .overflow_irq, .compare_a_irq, .compare_b_irq, .crystal_osc_enable,
  .ext_clock_buffer_enable
);

//--- testbench/slow_osc_model.sv
// Behavioural slow crystal or external clock driving the slow pin.
`timescale 1ns/1ps
module slow_osc_model #(
  parameter int HALF_NS = 15259
) (
  input  wire logic run,
  output logic      pin
);
  // The pin stands still low between bursts, so no stray tick occurs.
  initial begin
    pin = 1'b0;
    forever begin
      wait (run === 1'b1);
      pin = 1'b1;
      #HALF_NS;
      pin = 1'b0;
      #HALF_NS;
    end
  end
endmodule

//--- testbench/tb_async_timer_flags_sync.sv
// Self-checking testbench for the asynchronous timer status block.
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb_async_timer_flags_sync;
  logic        mclk = 1'b0;
  logic        reset_n;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        global_int_enable;
  logic [2:0]  ack;
  logic        overflow_irq;
  logic        compare_a_irq;
  logic        compare_b_irq;
  logic        crystal_osc_enable;
  logic        ext_clock_buffer_enable;
  logic        pin;
  logic        osc_run;
  logic        ce;
  logic [31:0] rd;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;

  always #20 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  slow_osc_model osc_u (.run(osc_run), .pin(pin));
  async_timer_flags_sync dut_u (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .global_int_enable(global_int_enable),
    .overflow_vector_ack(ack[0]), .compare_a_vector_ack(ack[1]),
    .compare_b_vector_ack(ack[2]), .overflow_irq(overflow_irq),
    .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
    .slow_osc_input_pin(pin), .crystal_osc_enable(crystal_osc_enable),
    .ext_clock_buffer_enable(ext_clock_buffer_enable)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] i,
                      input logic [7:0] d, input logic be);
    int n;
    n = 0;
    address <= {i, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    byteenable <= {3'h0, be};
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) fails++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d, 1'b1);
  endtask
  task automatic rg(input logic [7:0] i);
    xfer(1'b0, i, 8'h00, 1'b1);
  endtask
  task automatic poll(input logic [7:0] i, input logic [7:0] m,
                      input logic [7:0] v);
    int n;
    n = 0;
    do begin
      rg(i);
      n++;
    end while ((rd[7:0] & m) !== v && n < 1000);
  endtask
  task automatic pulse(input logic [2:0] a);
    ack <= a;
    @(posedge mclk);
    ack <= 3'h0;
    @(posedge mclk);
  endtask

  task automatic t_reset;
    rg(`IDX_ASYNC); chk(rd, 32'h0);
    rg(`IDX_GTC); chk(rd, 32'h0);
    rg(`IDX_MASK); chk(rd, 32'h0);
    rg(`IDX_FLAGS); chk(rd, 32'h0);
    wr(8'h00, 8'hFF);
    rg(8'h00); chk(rd, 32'h0);
    xfer(1'b1, `IDX_CMP_B, 8'h77, 1'b0);
    rg(`IDX_CMP_B); chk(rd, 32'h0);
  endtask
  task automatic t_flags;
    wr(`IDX_CMP_A, 8'h10);
    wr(`IDX_CMP_B, 8'h20);
    wr(`IDX_MASK, 8'h07);
    global_int_enable <= 1'b1;
    wr(`IDX_CTL_B, 8'h01);
    poll(`IDX_FLAGS, 8'h07, 8'h07); chk(rd, 32'h07);
    wr(`IDX_CTL_B, 8'h00);
    chk_pin(overflow_irq, 1'b1);
    chk_pin(compare_a_irq & compare_b_irq, 1'b1);
    wr(`IDX_MASK, 8'h06);
    @(posedge mclk);
    chk_pin(overflow_irq, 1'b0);
    global_int_enable <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_pin(compare_a_irq | compare_b_irq, 1'b0);
    pulse(3'h2);
    rg(`IDX_FLAGS); chk(rd, 32'h05);
    wr(`IDX_FLAGS, 8'h04);
    rg(`IDX_FLAGS); chk(rd, 32'h01);
    pulse(3'h1);
    rg(`IDX_FLAGS); chk(rd, 32'h00);
  endtask
  task automatic t_pwm;
    int t0;
    wr(`IDX_CTL_A, 8'h01);
    wr(`IDX_COUNTER, 8'h80);
    wr(`IDX_FLAGS, 8'h07);
    t0 = cyc;
    wr(`IDX_CTL_B, 8'h01);
    poll(`IDX_FLAGS, 8'h01, 8'h01);
    chk_pin(cyc - t0 > 300, 1'b1);
    wr(`IDX_CTL_B, 8'h00);
    wr(`IDX_CTL_A, 8'h00);
  endtask
  task automatic t_async;
    wr(`IDX_ASYNC, 8'h40);
    wr(`IDX_ASYNC, 8'h60);
    rg(`IDX_ASYNC); chk(rd, 32'h60);
    chk_pin(ext_clock_buffer_enable, 1'b1);
    chk_pin(crystal_osc_enable, 1'b0);
    // Each register is written once only, while it is not busy.
    wr(`IDX_CMP_A, 8'h5A);
    wr(`IDX_CMP_B, 8'h44);
    wr(`IDX_COUNTER, 8'h33);
    wr(`IDX_CTL_A, 8'h00);
    wr(`IDX_CTL_B, 8'h00);
    rg(`IDX_ASYNC); chk(rd, 32'h7F);
    rg(`IDX_CMP_A); chk(rd, 32'h5A);
    osc_run <= 1'b1;
    poll(`IDX_ASYNC, 8'h1F, 8'h00);
    osc_run <= 1'b0;
    chk(rd, 32'h60);
    rg(`IDX_COUNTER); chk(rd, 32'h33);
  endtask
  task automatic t_presc;
    wr(`IDX_GTC, 8'h02);
    rg(`IDX_GTC); chk(rd, 32'h02);
    osc_run <= 1'b1;
    poll(`IDX_GTC, 8'h02, 8'h00);
    osc_run <= 1'b0;
    chk(rd, 32'h00);
    wr(`IDX_ASYNC, 8'h00);
    wr(`IDX_ASYNC, 8'h20);
    @(posedge mclk);
    chk_pin(crystal_osc_enable, 1'b1);
    chk_pin(ext_clock_buffer_enable, 1'b0);
    wr(`IDX_ASYNC, 8'h00);
    wr(`IDX_COUNTER, 8'h00);
    wr(`IDX_GTC, 8'h82);
    repeat (4) @(posedge mclk);
    rg(`IDX_GTC); chk(rd, 32'h82);
    wr(`IDX_GTC, 8'h02);
    rg(`IDX_GTC); chk(rd, 32'h00);
    // With the clock enable low a pending write must stay unanswered.
    ce <= 1'b0;
    address <= {`IDX_MASK, 2'b00};
    write <= 1'b1;
    writedata <= 32'h00000005;
    byteenable <= 4'h1;
    repeat (3) @(posedge mclk);
    chk_pin(waitrequest, 1'b1);
    ce <= 1'b1;
    wr(`IDX_MASK, 8'h05);
    rg(`IDX_MASK); chk(rd, 32'h05);
  endtask

  task automatic close_out;
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    fails++;
    close_out;
  end

  initial begin
    reset_n = 1'b0;
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    global_int_enable = 1'b0;
    ack = 3'h0;
    osc_run = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_flags;
    t_pwm;
    t_async;
    t_presc;
    close_out;
  end
endmodule
